// file: verilog/ddcmx_pkg.sv
package ddcmx_pkg;
  localparam logic [11:0] DDCMX_OFS_PHASE4 = 12'h0361;
  localparam logic [11:0] DDCMX_OFS_PHASE5 = 12'h0362;
  localparam logic [11:0] DDCMX_OFS_TEST = 12'h0367;
  localparam logic [11:0] DDCMX_OFS_CTRL = 12'h0370;
  localparam logic [11:0] DDCMX_OFS_ALT = 12'h0371;
  localparam logic [7:0] DDCMX_RST_BYTE = 8'h00;
  localparam logic [7:0] DDCMX_RST_ALT = 8'h05;
  localparam logic [7:0] DDCMX_TEST_MASK = 8'h05;
  localparam logic [7:0] DDCMX_ALT_MASK = 8'hf5;
  localparam int DDCMX_TEST_I_BIT = 0;
  localparam int DDCMX_TEST_Q_BIT = 2;
  localparam int DDCMX_MIX_BIT = 7;
  localparam int DDCMX_GAIN_BIT = 6;
  localparam int DDCMX_IF_LSB = 4;
  localparam int DDCMX_C2R_BIT = 3;

  typedef enum logic [1:0] {DDCMX_IF_VAR, DDCMX_IF_ZERO, DDCMX_IF_FS, DDCMX_IF_TEST} ddcmx_if_t;

  typedef struct packed {
    logic [7:0] phase4;
    logic [7:0] phase5;
    logic [7:0] test_en;
    logic [7:0] ctrl;
    logic [7:0] alt;
    logic ack;
    logic [7:0] rdata;
  } ddcmx_state_t;

  typedef struct packed {
    logic complex_mix;
    logic gain_x2;
    ddcmx_if_t if_mode;
    logic c2r;
    logic [4:0] stage_en;
    logic [5:0] decim;
    logic decim_valid;
  } ddcmx_cfg_t;
endpackage

// file: verilog/ddcmx_config.sv
`timescale 1ns/1ps
module ddcmx_config
  import ddcmx_pkg::*;
#(
  parameter int SAMPLE_W = 16
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [SAMPLE_W-1:0] ddc_i_i,
  input wire logic [SAMPLE_W-1:0] ddc_q_i,
  input wire logic [SAMPLE_W-1:0] pattern_a_i,
  input wire logic [SAMPLE_W-1:0] pattern_b_i,
  output logic [SAMPLE_W-1:0] out_i_o,
  output logic [SAMPLE_W-1:0] out_q_o,
  output logic [15:0] phase_offset_hi_o,
  output ddcmx_cfg_t cfg_o
);
  ddcmx_state_t st, next_st;
  logic req;
  logic [SAMPLE_W-1:0] out_i, out_q, next_out_i, next_out_q;

  // stage enables: {fifthband, thirdband, halfband four, three, two}; halfband one always on
  function automatic logic [11:0] decode(input logic [2:0] code, input logic [3:0] alt,
                                         input logic c2r);
    logic [4:0] en;
    logic [5:0] f;
    logic ok;
    en = 5'h00;
    f = 6'h00;
    ok = 1'b1;
    case (code)
      3'h0: begin en = 5'h01; f = 6'h04; end
      3'h1: begin en = 5'h03; f = 6'h08; end
      3'h2: begin en = 5'h07; f = 6'h10; end
      3'h3: begin en = 5'h00; f = 6'h02; end
      3'h4: begin en = 5'h08; f = 6'h06; end
      3'h5: begin en = 5'h09; f = 6'h0c; end
      3'h6: begin en = 5'h0b; f = 6'h18; end
      default:
      begin
        case (alt)
          4'h0: begin en = 5'h0f; f = 6'h30; end
          4'h2: begin en = 5'h10; f = 6'h0a; end
          4'h3: begin en = 5'h11; f = 6'h14; end
          4'h4: begin en = 5'h13; f = 6'h28; end
          default: begin en = 5'h00; f = 6'h00; ok = 1'b0; end
        endcase
      end
    endcase
    if (c2r)
    begin
      f = {1'b0, f[5:1]};
    end
    return {en, f, ok};
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  logic wr_any, rd_any, wr_ctrl;
  assign wr_any = req && wb_we_i && wb_sel_i;
  assign rd_any = req && !wb_we_i;
  assign wr_ctrl = wr_any && wb_adr_i == DDCMX_OFS_CTRL;

  always_comb
  begin
    next_st = st;
    next_st.ack = req;
    if (req && wb_we_i && wb_sel_i)
    begin
      case (wb_adr_i)
        DDCMX_OFS_PHASE4: next_st.phase4 = wb_dat_i;
        DDCMX_OFS_PHASE5: next_st.phase5 = wb_dat_i;
        DDCMX_OFS_TEST: next_st.test_en = wb_dat_i & DDCMX_TEST_MASK;
        DDCMX_OFS_CTRL: next_st.ctrl = wb_dat_i;
        DDCMX_OFS_ALT: next_st.alt = wb_dat_i & DDCMX_ALT_MASK;
        default: next_st.ctrl = st.ctrl;
      endcase
    end
    case (wb_adr_i)
      DDCMX_OFS_PHASE4: next_st.rdata = st.phase4;
      DDCMX_OFS_PHASE5: next_st.rdata = st.phase5;
      DDCMX_OFS_TEST: next_st.rdata = st.test_en & DDCMX_TEST_MASK;
      DDCMX_OFS_CTRL: next_st.rdata = st.ctrl;
      DDCMX_OFS_ALT: next_st.rdata = st.alt;
      default: next_st.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '{DDCMX_RST_BYTE, DDCMX_RST_BYTE, DDCMX_RST_BYTE, DDCMX_RST_BYTE,
              DDCMX_RST_ALT, 1'b0, 8'h00};
      out_i <= '0;
      out_q <= '0;
    end
    else
    begin
      st <= next_st;
      out_i <= next_out_i;
      out_q <= next_out_q;
    end
  end

  logic [11:0] dec;
  always_comb
  begin
    dec = decode(st.ctrl[2:0], st.alt[7:4], st.ctrl[DDCMX_C2R_BIT]);
    cfg_o.complex_mix = st.ctrl[DDCMX_MIX_BIT];
    cfg_o.gain_x2 = st.ctrl[DDCMX_GAIN_BIT];
    cfg_o.if_mode = ddcmx_if_t'(st.ctrl[DDCMX_IF_LSB +: 2]);
    cfg_o.c2r = st.ctrl[DDCMX_C2R_BIT];
    cfg_o.stage_en = dec[11:7];
    cfg_o.decim = dec[6:1];
    cfg_o.decim_valid = dec[0];
  end

  // pattern content itself is chosen upstream by the per-channel select
  always_comb
  begin
    next_out_i = st.test_en[DDCMX_TEST_I_BIT] ? pattern_a_i : ddc_i_i;
    next_out_q = st.test_en[DDCMX_TEST_Q_BIT] ? pattern_b_i : ddc_q_i;
    if (st.ctrl[DDCMX_C2R_BIT])
    begin
      next_out_q = '0;
    end
  end

  assign out_i_o = out_i;
  assign out_q_o = out_q;
  assign phase_offset_hi_o = {st.phase5, st.phase4};
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;

  property p_test_i;
    @(posedge clk_i) disable iff (rst_i)
    st.test_en[DDCMX_TEST_I_BIT] |=> out_i_o == $past(pattern_a_i);
  endproperty
  a_test_i: assert property (p_test_i) else $error("i test pattern not applied");

  property p_test_q;
    @(posedge clk_i) disable iff (rst_i)
    (st.test_en[DDCMX_TEST_Q_BIT] && !st.ctrl[DDCMX_C2R_BIT]) |=>
      out_q_o == $past(pattern_b_i);
  endproperty
  a_test_q: assert property (p_test_q) else $error("q test pattern not applied");

  property p_resv;
    @(posedge clk_i) disable iff (rst_i)
    (st.test_en & ~DDCMX_TEST_MASK) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved test bits set");

  property p_phase;
    @(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && wb_sel_i && wb_adr_i == DDCMX_OFS_PHASE5) |=>
      phase_offset_hi_o[15:8] == $past(wb_dat_i);
  endproperty
  a_phase: assert property (p_phase) else $error("phase byte not stored");

  property p_c2r;
    @(posedge clk_i) disable iff (rst_i)
    cfg_o.c2r |=> out_q_o == '0;
  endproperty
  a_c2r: assert property (p_c2r) else $error("q not quiet in real mode");

  property p_hb;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h2 && !cfg_o.c2r) |-> cfg_o.decim == 6'h10 && cfg_o.stage_en == 5'h07;
  endproperty
  a_hb: assert property (p_hb) else $error("four half-band factor wrong");

  property p_one;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h3) |-> cfg_o.decim == (cfg_o.c2r ? 6'h01 : 6'h02);
  endproperty
  a_one: assert property (p_one) else $error("single half-band factor wrong");

  property p_tb;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h6) |-> cfg_o.decim == (cfg_o.c2r ? 6'h0c : 6'h18);
  endproperty
  a_tb: assert property (p_tb) else $error("third-band factor wrong");

  property p_alt;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h7 && st.alt[7:4] == 4'h0) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h18 : 6'h30);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate factor wrong");

  property p_phase_lo;
    @(posedge clk_i) disable iff (rst_i)
    (wr_any && wb_adr_i == DDCMX_OFS_PHASE4) |=> phase_offset_hi_o[7:0] == $past(wb_dat_i);
  endproperty
  a_phase_lo: assert property (p_phase_lo) else $error("low phase byte not stored");

  property p_phase_hold;
    @(posedge clk_i) disable iff (rst_i)
    !wr_any |=> $stable(phase_offset_hi_o);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase changed without write");

  property p_i_off;
    @(posedge clk_i) disable iff (rst_i)
    !st.test_en[DDCMX_TEST_I_BIT] |=> out_i_o == $past(ddc_i_i);
  endproperty
  a_i_off: assert property (p_i_off) else $error("i sample not passed");

  property p_q_off;
    @(posedge clk_i) disable iff (rst_i)
    (!st.test_en[DDCMX_TEST_Q_BIT] && !st.ctrl[DDCMX_C2R_BIT]) |=> out_q_o == $past(ddc_q_i);
  endproperty
  a_q_off: assert property (p_q_off) else $error("q sample not passed");

  property p_pat;
    @(posedge clk_i) disable iff (rst_i)
    (st.test_en == DDCMX_TEST_MASK && !st.ctrl[DDCMX_C2R_BIT]) |=>
      out_i_o == $past(pattern_a_i) && out_q_o == $past(pattern_b_i);
  endproperty
  a_pat: assert property (p_pat) else $error("pattern source mixed up");

  property p_mix;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> cfg_o.complex_mix == $past(wb_dat_i[DDCMX_MIX_BIT]);
  endproperty
  a_mix: assert property (p_mix) else $error("mixer select not stored");

  property p_gain;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> cfg_o.gain_x2 == $past(wb_dat_i[DDCMX_GAIN_BIT]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain select not stored");

  property p_ifm;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> cfg_o.if_mode == $past(wb_dat_i[DDCMX_IF_LSB +: 2]);
  endproperty
  a_ifm: assert property (p_ifm) else $error("if mode not stored");

  property p_c2r_cfg;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> cfg_o.c2r == $past(wb_dat_i[DDCMX_C2R_BIT]);
  endproperty
  a_c2r_cfg: assert property (p_c2r_cfg) else $error("real mode bit not stored");

  property p_c2r_i;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[DDCMX_C2R_BIT] && !st.test_en[DDCMX_TEST_I_BIT]) |=> out_i_o == $past(ddc_i_i);
  endproperty
  a_c2r_i: assert property (p_c2r_i) else $error("i lost in real mode");

  property p_dec0;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h0) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h02 : 6'h04) && cfg_o.stage_en == 5'h01;
  endproperty
  a_dec0: assert property (p_dec0) else $error("two half-band setting wrong");

  property p_dec1;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h1) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h04 : 6'h08) && cfg_o.stage_en == 5'h03;
  endproperty
  a_dec1: assert property (p_dec1) else $error("three half-band setting wrong");

  property p_dec2;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h2 && cfg_o.c2r) |-> cfg_o.decim == 6'h08 && cfg_o.stage_en == 5'h07;
  endproperty
  a_dec2: assert property (p_dec2) else $error("four half-band real factor wrong");

  property p_one_en;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h3) |-> cfg_o.stage_en == 5'h00 && cfg_o.decim_valid;
  endproperty
  a_one_en: assert property (p_one_en) else $error("single half-band stages wrong");

  property p_tb1;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h4) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h03 : 6'h06) && cfg_o.stage_en == 5'h08;
  endproperty
  a_tb1: assert property (p_tb1) else $error("third-band one stage wrong");

  property p_tb2;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h5) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h06 : 6'h0c) && cfg_o.stage_en == 5'h09;
  endproperty
  a_tb2: assert property (p_tb2) else $error("third-band two stage wrong");

  property p_tb_en;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h6) |-> cfg_o.stage_en == 5'h0b;
  endproperty
  a_tb_en: assert property (p_tb_en) else $error("third-band three stages wrong");

  property p_alt_ok;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] != 3'h7) |-> cfg_o.decim_valid;
  endproperty
  a_alt_ok: assert property (p_alt_ok) else $error("primary code flagged invalid");

  property p_alt_bad;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h7 && !(st.alt[7:4] inside {4'h0, 4'h2, 4'h3, 4'h4})) |->
      !cfg_o.decim_valid && cfg_o.decim == 6'h00 && cfg_o.stage_en == 5'h00;
  endproperty
  a_alt_bad: assert property (p_alt_bad) else $error("undefined alternate code used");

  property p_fb1;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h7 && st.alt[7:4] == 4'h2) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h05 : 6'h0a) && cfg_o.stage_en == 5'h10;
  endproperty
  a_fb1: assert property (p_fb1) else $error("fifth-band one stage wrong");

  property p_fb2;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h7 && st.alt[7:4] == 4'h3) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h0a : 6'h14) && cfg_o.stage_en == 5'h11;
  endproperty
  a_fb2: assert property (p_fb2) else $error("fifth-band two stage wrong");

  property p_fb3;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h7 && st.alt[7:4] == 4'h4) |->
      cfg_o.decim == (cfg_o.c2r ? 6'h14 : 6'h28) && cfg_o.stage_en == 5'h13;
  endproperty
  a_fb3: assert property (p_fb3) else $error("fifth-band three stage wrong");

  property p_alt_en;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[2:0] == 3'h7 && st.alt[7:4] == 4'h0) |-> cfg_o.stage_en == 5'h0f;
  endproperty
  a_alt_en: assert property (p_alt_en) else $error("alternate zero stages wrong");

  property p_resv_rd;
    @(posedge clk_i) disable iff (rst_i)
    (rd_any && wb_adr_i == DDCMX_OFS_TEST) |=> (wb_dat_o & ~DDCMX_TEST_MASK) == 8'h00;
  endproperty
  a_resv_rd: assert property (p_resv_rd) else $error("reserved test bits read back");

  property p_test_wr;
    @(posedge clk_i) disable iff (rst_i)
    (wr_any && wb_adr_i == DDCMX_OFS_TEST) |=>
      st.test_en == ($past(wb_dat_i) & DDCMX_TEST_MASK);
  endproperty
  a_test_wr: assert property (p_test_wr) else $error("test enable write wrong");
endmodule

// file: bench/ddc_mixer_decimation_config_tb.sv
`timescale 1ns/1ps
module ddc_mixer_decimation_config_tb;
  import ddcmx_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic sel = 1'h1;
  logic ack;
  logic [11:0] adr = 12'h000;
  logic [7:0] dat = 8'h00;
  logic [7:0] rdat;
  logic [7:0] rd;
  logic [15:0] di = 16'h1111;
  logic [15:0] dq = 16'h2222;
  logic [15:0] pa = 16'h3333;
  logic [15:0] pb = 16'h4444;
  logic [15:0] oi;
  logic [15:0] oq;
  logic [15:0] ph;
  ddcmx_cfg_t cfg;
  int n_errors = 0;
  int n_compared = 0;
  // columns: control byte, alternate byte, factor, stage enables
  logic [7:0] tab [13][4];
  logic [11:0] ra [5];

  ddcmx_config uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ddc_i_i(di), .ddc_q_i(dq), .pattern_a_i(pa), .pattern_b_i(pb), .out_i_o(oi),
    .out_q_o(oq), .phase_offset_hi_o(ph), .cfg_o(cfg));

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // single classic cycle; holds everything until ack is sampled high or 20 clocks pass
  task wb(input logic w, input logic s, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= s;
    adr <= a;
    dat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    chk("ack", 16'h0001, {15'h0000, ack});
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge clk_i);
    n_errors++;
    finish_test;
  end

  initial
  begin
    tab = '{'{8'h00, 8'h05, 8'h04, 8'h01}, '{8'h01, 8'h05, 8'h08, 8'h03},
      '{8'h92, 8'h05, 8'h10, 8'h07}, '{8'h0a, 8'h05, 8'h08, 8'h07},
      '{8'h6b, 8'h05, 8'h01, 8'h00},
      '{8'hf4, 8'h05, 8'h06, 8'h08}, '{8'h0d, 8'h05, 8'h06, 8'h09},
      '{8'h06, 8'h05, 8'h18, 8'h0b}, '{8'h07, 8'h05, 8'h30, 8'h0f},
      '{8'h0f, 8'h05, 8'h18, 8'h0f}, '{8'h07, 8'h25, 8'h0a, 8'h10},
      '{8'h0f, 8'h35, 8'h0a, 8'h11}, '{8'h07, 8'h45, 8'h28, 8'h13}};
    ra = '{DDCMX_OFS_PHASE4, DDCMX_OFS_PHASE5, DDCMX_OFS_TEST, DDCMX_OFS_CTRL, DDCMX_OFS_ALT};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int j = 0; j < 5; j++)
    begin
      wb(1'h0, 1'h1, ra[j], 8'h00);
      chk("reset value", (j == 4) ? 16'h0005 : 16'h0000, {8'h00, rd});
    end
    $display("reset test done");
    foreach (tab[j])
    begin
      wb(1'h1, 1'h1, DDCMX_OFS_CTRL, tab[j][0]);
      wb(1'h1, 1'h1, DDCMX_OFS_ALT, tab[j][1]);
      chk("factor", {8'h00, tab[j][2]}, {10'h000, cfg.decim});
      chk("stages", {8'h00, tab[j][3]}, {11'h000, cfg.stage_en});
      chk("ctrl bits", {10'h000, tab[j][0][7:3], 1'h1},
        {10'h000, cfg.complex_mix, cfg.gain_x2, cfg.if_mode, cfg.c2r, cfg.decim_valid});
    end
    wb(1'h1, 1'h1, DDCMX_OFS_ALT, 8'h15);
    chk("bad alternate", 16'h0000, {4'h0, cfg.stage_en, cfg.decim, cfg.decim_valid});
    $display("table test done");
    wb(1'h1, 1'h1, DDCMX_OFS_PHASE4, 8'ha5);
    wb(1'h1, 1'h1, DDCMX_OFS_PHASE5, 8'h3c);
    chk("phase out", 16'h3ca5, ph);
    wb(1'h0, 1'h1, DDCMX_OFS_PHASE5, 8'h00);
    chk("phase read", 16'h003c, {8'h00, rd});
    wb(1'h1, 1'h0, DDCMX_OFS_PHASE4, 8'h00);
    wb(1'h1, 1'h1, 12'h0363, 8'hff);
    wb(1'h0, 1'h1, 12'h0363, 8'h00);
    chk("unmapped read", 16'h0000, {8'h00, rd});
    chk("sel low write", 16'h3ca5, ph);
    wb(1'h0, 1'h1, DDCMX_OFS_PHASE4, 8'h00);
    chk("phase low read", 16'h00a5, {8'h00, rd});
    $display("phase test done");
    wb(1'h1, 1'h1, DDCMX_OFS_CTRL, 8'h00);
    wb(1'h1, 1'h1, DDCMX_OFS_TEST, 8'hff);
    wb(1'h0, 1'h1, DDCMX_OFS_TEST, 8'h00);
    chk("test enable read", 16'h0005, {8'h00, rd});
    chk("i pattern", pa, oi);
    chk("q pattern", pb, oq);
    wb(1'h1, 1'h1, DDCMX_OFS_TEST, 8'h01);
    repeat (2) @(posedge clk_i);
    #1;
    chk("q sample", dq, oq);
    chk("i pattern held", pa, oi);
    wb(1'h1, 1'h1, DDCMX_OFS_TEST, 8'h00);
    wb(1'h1, 1'h1, DDCMX_OFS_CTRL, 8'h08);
    repeat (2) @(posedge clk_i);
    #1;
    chk("i sample", di, oi);
    chk("q real only", 16'h0000, oq);
    $display("datapath test done");
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 1'h1, DDCMX_OFS_ALT, 8'h00);
    chk("alt after reset", 16'h0005, {8'h00, rd});
    chk("phase after reset", 16'h0000, ph);
    $display("second reset test done");
    finish_test;
  end
endmodule
